/* design/ssw_consts.svh */
`ifndef SSW_CONSTS_SVH
`define SSW_CONSTS_SVH

`define SSW_CLK_MHZ          125
`define SSW_COMM_TIMEOUT_US  40960
`define SSW_COMM_TIMEOUT_CYC (`SSW_COMM_TIMEOUT_US * `SSW_CLK_MHZ + 1)
`define SSW_TOGGLE_TIMEOUT_US  327000
`define SSW_TOGGLE_TIMEOUT_CYC (`SSW_TOGGLE_TIMEOUT_US * `SSW_CLK_MHZ)
`define SSW_TIMER_W          26

`define SSW_ST_S0            0
`define SSW_ST_S1            1
`define SSW_ST_S2            2
`define SSW_ST_S3            3
`define SSW_STATUS_RESET     4'h0

`define SSW_ID_CODE_NIBBLE   4'ha
`define SSW_AB_SELECT_BIT    3

`endif

/* design/ssw_pkg.sv */
package ssw_pkg;

  typedef struct packed {
    logic dataExchange;
    logic writeParam;
    logic deleteAddr;
    logic readStatus;
    logic readIdExt;
    logic writeIdExt;
  } ssw_req_t;

  typedef struct packed {
    logic       watchdogActive;
    logic       portGatedWatchdogFlag;
    logic       nibbleAlternateModeFlag;
    logic       extAddrMode;
    logic       idExtensionProtectFlag;
    logic [3:0] idCode;
    logic [3:0] factoryIdExtensionCopy;
    logic [3:0] userIdExtension;
  } ssw_cfg_t;

  typedef struct packed {
    logic nvmWriteBusy;
    logic addrVolatile;
    logic peripheralFault;
    logic areaParityError;
    logic nvmCorrupt;
  } ssw_nvm_t;

  typedef enum logic [1:0] {MON_OFF, MON_RUN, MON_LOST} ssw_mon_t;

endpackage

/* design/ssw_timeout.sv */
`timescale 1ns/1ps
`default_nettype none
module ssw_timeout #(
  parameter int LIMIT = 16,
  parameter int W     = 26
) (
  input  wire logic clk_sys,  // System clock
  input  wire logic srst,     // Sync reset
  input  wire logic run,      // Count while high
  input  wire logic restart,  // Back to zero
  output logic      expired   // One pulse at limit
);
  localparam logic [W-1:0] LIM = W'(LIMIT);
  logic [W-1:0] cnt_reg, cnt_next;
  logic         expired_reg, expired_next;

  always_comb begin
    cnt_next     = cnt_reg;
    expired_next = 1'b0;
    if (!run || restart) begin
      cnt_next = '0;
    end else if (cnt_reg != LIM) begin
      cnt_next     = cnt_reg + W'(1);
      expired_next = (cnt_next == LIM);
    end
  end

  // Saturates at the limit so one silence gives one pulse
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cnt_reg     <= '0;
      expired_reg <= 1'b0;
    end else begin
      cnt_reg     <= cnt_next;
      expired_reg <= expired_next;
    end
  end

  assign expired = expired_reg;
endmodule
`default_nettype wire

/* design/ssw_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ssw_consts.svh"
module ssw_top
  import ssw_pkg::*;
#(
  parameter int COMM_TIMEOUT_CYC   = `SSW_COMM_TIMEOUT_CYC,
  parameter int TOGGLE_TIMEOUT_CYC = `SSW_TOGGLE_TIMEOUT_CYC,
  parameter int TIMER_W            = `SSW_TIMER_W
) (
  input  wire logic       clk_sys,             // 125 MHz system clock
  input  wire logic       srst,                // IC reset, sync, high
  input  wire ssw_req_t   req,                 // Decoded request pulses
  input  wire logic       addrNonzero,         // Slave address not zero
  input  wire logic       dataBitI2,           // I2 of current exchange
  input  wire logic [3:0] idWriteData,         // Data of ID extension write
  input  wire ssw_cfg_t   cfg,                 // Stored configuration
  input  wire ssw_nvm_t   nvm,                 // Memory and fault state
  input  wire logic       parameterPortLineZero, // Pin, asynchronous
  output logic [3:0]      statusResp,          // Status answer nibble
  output logic            statusValid,         // Status answer strobe
  output logic [3:0]      idResp,              // ID extension answer
  output logic            idRespValid,         // ID answer strobe
  output logic            nvmWriteStart,       // Start ID extension write
  output logic            redStatusIndicator,  // Red status LED
  output logic            wdReset,             // Unconditional reset pulse
  output logic            dataExchangeDisable  // Data port blocked
);

  ////////////////////////////////////////////////////////////////////////
  // Parameter port line synchroniser
  logic [2:0] p0Sync_reg, p0Sync_next;
  logic       p0Level_reg, p0Level_next;

  always_comb begin
    p0Sync_next  = {p0Sync_reg[1:0], parameterPortLineZero};
    p0Level_next = p0Level_reg;
    // Only stages two and three are compared; stage one may be metastable
    if (p0Sync_reg[1] == p0Sync_reg[2]) begin
      p0Level_next = p0Sync_reg[2];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      p0Sync_reg  <= 3'h0;
      p0Level_reg <= 1'b0;
    end else begin
      p0Sync_reg  <= p0Sync_next;
      p0Level_reg <= p0Level_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status word
  logic       delaS0_reg, delaS0_next;
  logic [3:0] statusWord;
  logic [3:0] statusResp_reg, statusResp_next;
  logic       statusValid_reg, statusValid_next;

  always_comb begin
    delaS0_next = delaS0_reg;
    // Cleared once an address is assigned again; the set wins
    if (addrNonzero) begin
      delaS0_next = 1'b0;
    end
    if (req.deleteAddr && addrNonzero) begin
      delaS0_next = 1'b1;
    end
    statusWord              = `SSW_STATUS_RESET;
    statusWord[`SSW_ST_S0]  = nvm.addrVolatile | nvm.nvmWriteBusy | delaS0_reg;
    statusWord[`SSW_ST_S1]  = nvm.peripheralFault | nvm.areaParityError;
    statusWord[`SSW_ST_S2]  = 1'b0;
    statusWord[`SSW_ST_S3]  = nvm.nvmCorrupt;
    statusResp_next  = statusResp_reg;
    statusValid_next = req.readStatus;
    if (req.readStatus) begin
      statusResp_next = statusWord;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      delaS0_reg      <= 1'b0;
      statusResp_reg  <= `SSW_STATUS_RESET;
      statusValid_reg <= 1'b0;
    end else begin
      delaS0_reg      <= delaS0_next;
      statusResp_reg  <= statusResp_next;
      statusValid_reg <= statusValid_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Communication monitor and toggle watchdog
  ssw_mon_t monState_reg, monState_next;
  logic     togEnable_reg, togEnable_next;
  logic     lastI2_reg, lastI2_next;
  logic     redLed_reg, redLed_next;
  logic     wdReset_reg, wdReset_next;
  logic     dataExDis_reg, dataExDis_next;
  logic     wdMode, togArmed, exchange, togFlip;
  logic     commExpire, togExpire;

  always_comb begin
    wdMode   = cfg.watchdogActive | (cfg.portGatedWatchdogFlag & p0Level_reg);
    togArmed = togEnable_reg && wdMode && cfg.nibbleAlternateModeFlag
               && (cfg.idCode == `SSW_ID_CODE_NIBBLE);
    exchange = req.dataExchange | req.writeParam;
    // Nibble halves alternate on I2; equal bits mean a stale half
    togFlip  = req.dataExchange && (dataBitI2 != lastI2_reg);
  end

  ssw_timeout #(
    .LIMIT (COMM_TIMEOUT_CYC),
    .W     (TIMER_W)
  ) u_comm_timer (
    .clk_sys (clk_sys),
    .srst    (srst),
    .run     (monState_reg == MON_RUN),
    .restart (exchange),
    .expired (commExpire)
  );

  ssw_timeout #(
    .LIMIT (TOGGLE_TIMEOUT_CYC),
    .W     (TIMER_W)
  ) u_toggle_timer (
    .clk_sys (clk_sys),
    .srst    (srst),
    .run     (togArmed),
    .restart (togFlip),
    .expired (togExpire)
  );

  always_comb begin
    monState_next  = monState_reg;
    togEnable_next = togEnable_reg;
    lastI2_next    = lastI2_reg;
    redLed_next    = redLed_reg;
    wdReset_next   = 1'b0;
    dataExDis_next = dataExDis_reg;
    if (req.dataExchange) begin
      lastI2_next = dataBitI2;
    end
    case (monState_reg)
      MON_OFF: begin
        if (req.writeParam && addrNonzero) begin
          monState_next = MON_RUN;
        end
      end
      MON_RUN: begin
        if (commExpire && !exchange) begin
          monState_next = MON_LOST;
          redLed_next   = 1'b1;
        end
      end
      MON_LOST: begin
        if (exchange) begin
          monState_next = MON_RUN;
          redLed_next   = 1'b0;
        end
      end
      default: begin
        monState_next = MON_OFF;
      end
    endcase
    if (req.dataExchange && addrNonzero) begin
      togEnable_next = 1'b1;
    end
    if (req.writeParam) begin
      dataExDis_next = 1'b0;
    end
    // One shared path so either expiry has the same effects
    if ((commExpire && !exchange && wdMode && monState_reg == MON_RUN)
        || (togExpire && togArmed && !togFlip)) begin
      wdReset_next   = 1'b1;
      dataExDis_next = 1'b1;
    end
    if (wdReset_reg || req.deleteAddr) begin
      monState_next  = MON_OFF;
      togEnable_next = 1'b0;
      redLed_next    = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      monState_reg  <= MON_OFF;
      togEnable_reg <= 1'b0;
      lastI2_reg    <= 1'b0;
      redLed_reg    <= 1'b0;
      wdReset_reg   <= 1'b0;
      dataExDis_reg <= 1'b0;
    end else begin
      monState_reg  <= monState_next;
      togEnable_reg <= togEnable_next;
      lastI2_reg    <= lastI2_next;
      redLed_reg    <= redLed_next;
      wdReset_reg   <= wdReset_next;
      dataExDis_reg <= dataExDis_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // ID extension protection
  logic [3:0] idResp_reg, idResp_next;
  logic       idRespValid_reg, idRespValid_next;
  logic       nvmStart_reg, nvmStart_next;
  logic [3:0] protMask, idProtRead;
  logic       idMismatch;

  always_comb begin
    // Bit 3 stays user owned as A/B selector in extended addressing
    protMask   = cfg.extAddrMode ? 4'h7 : 4'hf;
    idProtRead = (cfg.factoryIdExtensionCopy & protMask)
                 | (cfg.userIdExtension & ~protMask);
    idMismatch = ((idWriteData ^ cfg.factoryIdExtensionCopy) & protMask) != 4'h0;
    idResp_next      = idResp_reg;
    idRespValid_next = 1'b0;
    nvmStart_next    = 1'b0;
    if (req.readIdExt) begin
      idRespValid_next = 1'b1;
      idResp_next      = cfg.idExtensionProtectFlag ? idProtRead
                                                    : cfg.userIdExtension;
    end else if (req.writeIdExt) begin
      // A rejected write neither answers nor touches the memory
      if (!cfg.idExtensionProtectFlag || !idMismatch) begin
        idRespValid_next = 1'b1;
        nvmStart_next    = 1'b1;
        idResp_next      = idWriteData;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      idResp_reg      <= 4'h0;
      idRespValid_reg <= 1'b0;
      nvmStart_reg    <= 1'b0;
    end else begin
      idResp_reg      <= idResp_next;
      idRespValid_reg <= idRespValid_next;
      nvmStart_reg    <= nvmStart_next;
    end
  end

  assign statusResp          = statusResp_reg;
  assign statusValid         = statusValid_reg;
  assign idResp              = idResp_reg;
  assign idRespValid         = idRespValid_reg;
  assign nvmWriteStart       = nvmStart_reg;
  assign redStatusIndicator  = redLed_reg;
  assign wdReset             = wdReset_reg;
  assign dataExchangeDisable = dataExDis_reg;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  status_s2_zero_a: assert property (statusValid |-> !statusResp[`SSW_ST_S2]
  ) else $error("S2 not zero");
  status_read_a: assert property (req.readStatus |=> statusValid
    && statusResp[`SSW_ST_S3] == $past(nvm.nvmCorrupt)
    && statusResp[`SSW_ST_S1] == $past(nvm.peripheralFault | nvm.areaParityError)
  ) else $error("Status answer wrong");
  s0_write_busy_a: assert property (req.readStatus && nvm.nvmWriteBusy |=> statusResp[`SSW_ST_S0]
  ) else $error("S0 low during write");
  s0_delete_a: assert property (req.deleteAddr && addrNonzero ##1 !addrNonzero ##1 req.readStatus
    |=> statusResp[`SSW_ST_S0]) else $error("S0 not set by delete");
  red_on_a: assert property (monState_reg == MON_RUN && commExpire && !exchange
    && !req.deleteAddr && !wdReset_reg |=> redStatusIndicator) else $error("Red not lit");
  red_off_a: assert property (redStatusIndicator && exchange |=> !redStatusIndicator
  ) else $error("Red not cleared");
  mon_gate_a: assert property (monState_reg == MON_OFF && !(req.writeParam && addrNonzero)
    |=> monState_reg == MON_OFF) else $error("Monitor started wrongly");
  mon_stop_a: assert property (req.deleteAddr |=> monState_reg == MON_OFF && !togEnable_reg
  ) else $error("Delete did not stop");
  wd_reset_a: assert property (wdReset |-> dataExchangeDisable ##1 !wdReset
    ##1 monState_reg == MON_OFF || $past(req.writeParam)) else $error("Reset effects wrong");
  block_hold_a: assert property (dataExchangeDisable && !req.writeParam |=> dataExchangeDisable
  ) else $error("Data unblocked early");
  tog_fire_a: assert property (togExpire && togArmed && !togFlip |=> wdReset
  ) else $error("Toggle reset missing");
  id_prot_a: assert property (req.readIdExt && cfg.idExtensionProtectFlag && !cfg.extAddrMode
    |=> idRespValid && idResp == $past(cfg.factoryIdExtensionCopy)) else $error("Protected read wrong");
  id_reject_a: assert property (req.writeIdExt && !req.readIdExt && cfg.idExtensionProtectFlag
    && idMismatch |=> !idRespValid && !nvmWriteStart) else $error("Mismatch accepted");
  id_user_a: assert property (req.writeIdExt && !req.readIdExt && !cfg.idExtensionProtectFlag
    |=> nvmWriteStart && idRespValid) else $error("Write not accepted");

  cov_red_c: cover property (redStatusIndicator ##[1:20] !redStatusIndicator);
  cov_wd_c: cover property (wdReset);
  cov_reject_c: cover property (req.writeIdExt && cfg.idExtensionProtectFlag && idMismatch);
  cov_status_c: cover property (statusValid && statusResp[`SSW_ST_S0]);

endmodule
`default_nettype wire

/* verification/ssw_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ssw_master_model
  import ssw_pkg::*;
(
  input  wire logic       clk_sys,     // System clock
  output var  ssw_req_t   req,         // Request pulses
  output var  logic       dataBitI2,   // I2 of exchange
  output var  logic [3:0] idWriteData  // ID write data
);
  initial begin
    req = '0;
    dataBitI2 = 1'b0;
    idWriteData = 4'h0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Leading idle edge, so two calls never touch req in one step
  task automatic send(input ssw_req_t r);
    @(posedge clk_sys);
    #1 req = r;
    @(posedge clk_sys);
    #1 req = '0;
  endtask
  // High and low nibble alternate: flip set toggles I2, flip clear repeats the stale half
  task automatic exchange(input logic flip);
    if (flip) dataBitI2 = ~dataBitI2;
    send(6'h20);
  endtask
  task automatic writeId(input logic [3:0] d);
    idWriteData = d;
    send(6'h01);
  endtask
  // Selector change: value read back, only bit 3 flipped
  task automatic changeAb(input logic [3:0] readVal);
    writeId(readVal ^ 4'h8);
  endtask
endmodule
`default_nettype wire

/* verification/ssw_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module ssw_top_bench
  import ssw_pkg::*;
;
  localparam int         COMM_CYC = 20;
  localparam int         TOG_CYC  = 30;
  localparam int         LIMIT    = 3000;
  localparam logic [5:0] WP       = 6'h10;
  localparam logic [5:0] DEL      = 6'h08;
  logic       clk_sys;
  logic       srst;
  ssw_req_t   req;
  logic       addrNonzero;
  logic       dataBitI2;
  logic [3:0] idWriteData;
  ssw_cfg_t   cfg;
  ssw_nvm_t   nvm;
  logic       parameterPortLineZero;
  logic [3:0] statusResp;
  logic       statusValid;
  logic [3:0] idResp;
  logic       idRespValid;
  logic       nvmWriteStart;
  logic       redStatusIndicator;
  logic       wdReset;
  logic       dataExchangeDisable;
  logic [5:0] expQ[$];
  int         errors = 0;
  int         tests_run = 0;
  int         cycles = 0;

  ssw_top #(.COMM_TIMEOUT_CYC(COMM_CYC), .TOGGLE_TIMEOUT_CYC(TOG_CYC)) dut (
    .clk_sys(clk_sys), .srst(srst), .req(req), .addrNonzero(addrNonzero), .dataBitI2(dataBitI2),
    .idWriteData(idWriteData), .cfg(cfg), .nvm(nvm), .parameterPortLineZero(parameterPortLineZero),
    .statusResp(statusResp), .statusValid(statusValid), .idResp(idResp), .idRespValid(idRespValid),
    .nvmWriteStart(nvmWriteStart), .redStatusIndicator(redStatusIndicator), .wdReset(wdReset),
    .dataExchangeDisable(dataExchangeDisable));

  ssw_master_model master (.clk_sys(clk_sys), .req(req), .dataBitI2(dataBitI2), .idWriteData(idWriteData));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic mismatch(input string msg);
    errors++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask
  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) mismatch(msg);
  endtask
  // Kind 0 status, 1 accepted write, 2 read, 3 watchdog reset
  task automatic checkOut(input logic [1:0] kind, input logic [3:0] val);
    logic [5:0] exp;
    tests_run++;
    exp = (expQ.size() > 0) ? expQ.pop_front() : 6'h3f;
    if (exp !== {kind, val}) mismatch("response differs from expected");
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic done(input string name);
    // Last answer is popped one edge after its request
    idle(2);
    check(expQ.size() == 0, "expected response missing");
    $display("test %s done", name);
  endtask
  task automatic conclude;
    $display("checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Sampled well after the edge so registered outputs have settled
  always @(posedge clk_sys) begin
    #2;
    if (statusValid === 1'b1) checkOut(2'd0, statusResp);
    if (idRespValid === 1'b1) checkOut(nvmWriteStart ? 2'd1 : 2'd2, idResp);
    if (wdReset === 1'b1) checkOut(2'd3, {3'h0, dataExchangeDisable});
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatch("run did not finish in time");
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [3:0] rd;
    logic [3:0] mask;
    logic [1:0] sel;
    logic [1:0] idSel;
    srst = 1'b1;
    addrNonzero = 1'b1;
    parameterPortLineZero = 1'b0;
    cfg = '0;
    nvm = '0;
    void'($urandom(32'h1d6a));
    repeat (6) @(posedge clk_sys);
    #1 srst = 1'b0;
    for (int i = 0; i < 12; i++) begin
      nvm = 5'($urandom());
      expQ.push_back({2'd0, nvm.nvmCorrupt, 1'b0, nvm.peripheralFault | nvm.areaParityError,
                      nvm.addrVolatile | nvm.nvmWriteBusy});
      master.send(6'h04);
    end
    nvm = '0;
    master.send(DEL);
    addrNonzero = 1'b0;
    expQ.push_back(6'h01);
    master.send(6'h04);
    addrNonzero = 1'b1;
    done("status");
    // Random visiting order of the four protect and addressing modes
    idSel = 2'($urandom());
    for (int m = 0; m < 4; m++) begin
      sel = 2'(m) ^ idSel;
      // Inputs that the ID path must ignore get random values
      {cfg.watchdogActive, cfg.portGatedWatchdogFlag, cfg.nibbleAlternateModeFlag,
       addrNonzero, parameterPortLineZero} = 5'($urandom());
      cfg.idExtensionProtectFlag = sel[1];
      cfg.extAddrMode = sel[0];
      cfg.factoryIdExtensionCopy = 4'($urandom());
      cfg.userIdExtension = 4'($urandom());
      mask = sel[0] ? 4'h7 : 4'hf;
      rd = sel[1] ? (cfg.factoryIdExtensionCopy & mask) | (cfg.userIdExtension & ~mask) : cfg.userIdExtension;
      expQ.push_back({2'd2, rd});
      master.send(6'h02);
      if (!sel[1] || sel[0]) expQ.push_back({2'd1, rd ^ 4'h8});
      master.changeAb(rd);
      if (!sel[1]) expQ.push_back({2'd1, rd ^ 4'h1});
      master.writeId(rd ^ 4'h1);
    end
    done("id extension");
    cfg.watchdogActive = 1'b0;
    cfg.portGatedWatchdogFlag = 1'b0;
    cfg.nibbleAlternateModeFlag = 1'b0;
    parameterPortLineZero = 1'b0;
    addrNonzero = 1'b0;
    master.send(WP);
    idle(40);
    check(redStatusIndicator === 1'b0, "monitor started at zero address");
    addrNonzero = 1'b1;
    master.send(WP);
    idle(15);
    check(redStatusIndicator === 1'b0, "red lit too early");
    idle(8);
    check(redStatusIndicator === 1'b1, "red not lit after timeout");
    master.exchange(1'b0);
    idle(1);
    check(redStatusIndicator === 1'b0, "red not cleared by exchange");
    master.send(DEL);
    idle(40);
    check(redStatusIndicator === 1'b0, "monitor still running after delete");
    // Reset in mid run must stop a running monitor as well
    master.send(WP);
    idle(2);
    srst = 1'b1;
    idle(2);
    srst = 1'b0;
    idle(30);
    check(redStatusIndicator === 1'b0, "monitor survived reset");
    done("monitor");
    for (int k = 0; k < 3; k++) begin
      cfg.watchdogActive = (k == 0);
      cfg.portGatedWatchdogFlag = (k != 0);
      parameterPortLineZero = (k == 1);
      master.send(WP);
      if (k < 2) expQ.push_back(6'h31);
      idle(30);
      check(redStatusIndicator === (k == 2), "wrong monitor outcome");
      if (k < 2) begin
        master.exchange(1'b0);
        check(dataExchangeDisable === 1'b1, "exchange resumed without parameter write");
        master.send(WP);
        idle(1);
        check(dataExchangeDisable === 1'b0, "parameter write did not unblock");
      end
      master.send(DEL);
    end
    done("watchdog");
    cfg.watchdogActive = 1'b1;
    cfg.portGatedWatchdogFlag = 1'b0;
    cfg.nibbleAlternateModeFlag = 1'b1;
    cfg.idCode = 4'ha;
    for (int j = 0; j < 10; j++) begin
      master.exchange(1'b1);
      idle(8);
    end
    expQ.push_back(6'h31);
    for (int j = 0; j < 3; j++) begin
      master.exchange(1'b0);
      idle(8);
    end
    master.send(DEL);
    // Disarmed once by the mode flag, once by a profile code other than nibble mode
    for (int n = 0; n < 2; n++) begin
      cfg.nibbleAlternateModeFlag = (n == 1);
      if (n == 1) cfg.idCode = 4'ha ^ 4'(1 + $urandom_range(14));
      for (int j = 0; j < 6; j++) begin
        master.exchange(1'b0);
        idle(8);
      end
    end
    done("toggle watchdog");
    conclude();
  end
endmodule
`default_nettype wire
